// [aux_pwm_defs.svh]
// register offsets, field positions, reset values and timing for the dual auxiliary pulse timer
//
// Overview of operation
// - two outputs, each 16-bit period and on-time
// - mode bit 8 set: independent periods
// - counter steps every two clocks
// - high time is twice on-time value
// - on-time above period gives full duty
// - offset mode: first period shared by both
// - second rise lags by second period setting plus one step
// - new on-time applies at next cycle
// - period write clears counters, restarts cycles
// - mode bit 8 clear after reset
// - period registers reset to all ones
// - on-time registers reset to zero
// - period accepts full 16-bit range
// - pin carries pulse only when select clear
`ifndef AUX_PWM_DEFS_SVH
`define AUX_PWM_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register word indices on the apb bus, byte address is four times the index
`define AUX_OFS_PERIOD_0 3'h0
`define AUX_OFS_PERIOD_1 3'h1
`define AUX_OFS_ONTIME_0 3'h2
`define AUX_OFS_ONTIME_1 3'h3
`define AUX_OFS_MODE 3'h4
`define AUX_OFS_PINSEL 3'h5
`define AUX_OFS_STATUS 3'h6
`define AUX_OFS_COUNT 3'h7

////////////////////////////////////////////////////////////////////////////////
// field positions
`define AUX_MODE_INDEP_BIT 8
`define AUX_PINSEL_FIRST_BIT 8
`define AUX_PINSEL_SECOND_BIT 7

////////////////////////////////////////////////////////////////////////////////
// reset values
`define AUX_PERIOD_RST 16'hFFFF
`define AUX_ONTIME_RST 16'h0000
`define AUX_MODE_RST 16'h0000
`define AUX_PINSEL_RST 16'hFFFF

////////////////////////////////////////////////////////////////////////////////
// timing: one count step per two system clocks
`define AUX_CLK_PER_STEP 2

`endif

// [aux_pwm_pkg.sv]
// types shared by the dual auxiliary pulse timer
`default_nettype none

package aux_pwm_pkg;

  // one shared pin: level and drive enable
  typedef struct packed {
    logic out; // pin level
    logic oe;  // high while driven
  } pin_drive_s;

  // 16-bit register word
  typedef logic [15:0] word16_t;

  // operating mode of the pair
  typedef enum logic {
    MODE_OFFSET,
    MODE_INDEPENDENT
  } aux_mode_e;

endpackage : aux_pwm_pkg

`default_nettype wire

// [aux_pwm_channel.sv]
// one auxiliary pulse channel: cycle counter, latched on-time and pulse output
`timescale 1ns/1ns
`default_nettype none

module aux_pwm_channel (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic clear,
  input wire logic idle_on_clear,
  input wire logic start,
  input wire aux_pwm_pkg::word16_t period,
  input wire aux_pwm_pkg::word16_t ontime,
  output aux_pwm_pkg::word16_t count,
  output aux_pwm_pkg::word16_t on_eff,
  output logic running,
  output logic pulse
);
  import aux_pwm_pkg::*;

  word16_t count_r, count_nxt; // cycle position
  word16_t on_r, on_nxt;       // on-time in force this cycle
  logic run_r, run_nxt;        // counting, not waiting for start
  logic pulse_r, pulse_nxt;    // registered output

  ////////////////////////////////////////////////////////////////////////////
  // next state: clear beats start beats tick
  always_comb begin
    count_nxt = count_r;
    on_nxt = on_r;
    run_nxt = run_r;
    if (clear) begin
      // restart at zero, fresh on-time
      count_nxt = 16'h0000;
      on_nxt = ontime;
      run_nxt = ~idle_on_clear;
    end else if (start) begin
      // delayed start of a lagging channel
      count_nxt = 16'h0000;
      on_nxt = ontime;
      run_nxt = 1'b1;
    end else if (tick && run_r) begin
      if (count_r == period) begin
        // wrap: new cycle takes the stored on-time
        count_nxt = 16'h0000;
        on_nxt = ontime;
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end
    // high from cycle start while below on-time; above period never falls
    pulse_nxt = run_nxt && (count_nxt < on_nxt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count_r <= 16'h0000;
      on_r <= 16'h0000;
      run_r <= 1'b1;
      pulse_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      on_r <= on_nxt;
      run_r <= run_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign count = count_r;
  assign on_eff = on_r;
  assign running = run_r;
  assign pulse = pulse_r;

endmodule : aux_pwm_channel

`default_nettype wire

// [dual_aux_pwm_timer.sv]
// dual auxiliary pulse timer: apb registers, mode control, two channels, pin muxing
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "aux_pwm_defs.svh"

module dual_aux_pwm_timer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output aux_pwm_pkg::pin_drive_s pulse_out_first,
  output aux_pwm_pkg::pin_drive_s pulse_out_second
);
  import aux_pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  word16_t period_r [0:1]; // cycle length per channel
  word16_t period_nxt [0:1];
  word16_t ontime_r [0:1]; // requested on-time per channel
  word16_t ontime_nxt [0:1];
  word16_t mode_control_reg_r, mode_control_reg_nxt; // mode bits
  word16_t pin_function_select_r, pin_function_select_nxt; // pin muxing

  // apb answer
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // prescaler phase, tick on odd phase
  logic phase_r, phase_nxt;

  // pin drive
  pin_drive_s pin_first_r, pin_first_nxt;
  pin_drive_s pin_second_r, pin_second_nxt;

  // decode
  logic [2:0] reg_idx; // word index
  logic addr_hit; // address maps a register
  logic wr_en; // write commits this edge
  logic clear; // period write restarts cycles
  logic tick; // one count step
  aux_mode_e mode; // decoded mode

  // channel wiring
  word16_t ch_period [0:1];
  word16_t ch_count [0:1];
  word16_t ch_on [0:1];
  logic [1:0] ch_idle;
  logic [1:0] ch_start;
  logic [1:0] ch_run;
  logic [1:0] pwm;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and commit strobe
  assign reg_idx = paddr[4:2];
  assign addr_hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;
  assign clear = wr_en && ((reg_idx == `AUX_OFS_PERIOD_0) || (reg_idx == `AUX_OFS_PERIOD_1));
  assign tick = phase_r;
  assign mode = mode_control_reg_r[`AUX_MODE_INDEP_BIT] ? MODE_INDEPENDENT : MODE_OFFSET;

  // byte-lane merge for 16-bit registers
  function automatic word16_t merge16(input word16_t old, input logic [31:0] data, input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = data[7:0];
    if (strb[1]) merge16[15:8] = data[15:8];
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // register file next values
  always_comb begin
    period_nxt = period_r;
    ontime_nxt = ontime_r;
    mode_control_reg_nxt = mode_control_reg_r;
    pin_function_select_nxt = pin_function_select_r;
    if (wr_en) begin
      case (reg_idx)
        // any 16-bit value is legal
        `AUX_OFS_PERIOD_0: period_nxt[0] = merge16(period_r[0], pwdata, pstrb);
        `AUX_OFS_PERIOD_1: period_nxt[1] = merge16(period_r[1], pwdata, pstrb);
        // stored now, applied at next cycle start
        `AUX_OFS_ONTIME_0: ontime_nxt[0] = merge16(ontime_r[0], pwdata, pstrb);
        `AUX_OFS_ONTIME_1: ontime_nxt[1] = merge16(ontime_r[1], pwdata, pstrb);
        `AUX_OFS_MODE: mode_control_reg_nxt = merge16(mode_control_reg_r, pwdata, pstrb);
        `AUX_OFS_PINSEL: pin_function_select_nxt = merge16(pin_function_select_r, pwdata, pstrb);
        default: begin
          // status and count are read only
        end
      endcase
    end
  end

  // register file flops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      period_r[0] <= `AUX_PERIOD_RST;
      period_r[1] <= `AUX_PERIOD_RST;
      ontime_r[0] <= `AUX_ONTIME_RST;
      ontime_r[1] <= `AUX_ONTIME_RST;
      mode_control_reg_r <= `AUX_MODE_RST;
      pin_function_select_r <= `AUX_PINSEL_RST;
    end else begin
      period_r <= period_nxt;
      ontime_r <= ontime_nxt;
      mode_control_reg_r <= mode_control_reg_nxt;
      pin_function_select_r <= pin_function_select_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: ready in the first access cycle, data captured at setup
  always_comb begin
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !addr_hit;
    prdata_nxt = 32'h0000_0000;
    if (psel && !penable && addr_hit && !pwrite) begin
      case (reg_idx)
        `AUX_OFS_PERIOD_0: prdata_nxt = {16'h0000, period_r[0]};
        `AUX_OFS_PERIOD_1: prdata_nxt = {16'h0000, period_r[1]};
        `AUX_OFS_ONTIME_0: prdata_nxt = {16'h0000, ontime_r[0]};
        `AUX_OFS_ONTIME_1: prdata_nxt = {16'h0000, ontime_r[1]};
        `AUX_OFS_MODE: prdata_nxt = {16'h0000, mode_control_reg_r};
        `AUX_OFS_PINSEL: prdata_nxt = {16'h0000, pin_function_select_r};
        // live outputs and run state
        `AUX_OFS_STATUS: prdata_nxt = {29'h0000_0000, ch_run[1], pwm};
        // live counters
        `AUX_OFS_COUNT: prdata_nxt = {ch_count[1], ch_count[0]};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // apb answer flops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: one step every two clocks, realigned on restart
  always_comb begin
    phase_nxt = clear ? 1'b0 : !phase_r;
  end

  // prescaler flop
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel control: second channel shares first period in offset mode
  always_comb begin
    ch_period[0] = period_r[0];
    ch_idle[0] = 1'b0;
    ch_start[0] = 1'b0;
    if (mode == MODE_INDEPENDENT) begin
      ch_period[1] = period_r[1];
      ch_idle[1] = 1'b0;
      ch_start[1] = 1'b0;
    end else begin
      ch_period[1] = period_r[0];
      ch_idle[1] = 1'b1;
      // lag point reached; relies on second period below first
      ch_start[1] = tick && (ch_count[0] == period_r[1]) && !clear;
    end
  end

  // both channels from one template
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      aux_pwm_channel u_ch (
        .mclk(mclk),
        .nrst(nrst),
        .tick(tick),
        .clear(clear),
        .idle_on_clear(ch_idle[gi]),
        .start(ch_start[gi]),
        .period(ch_period[gi]),
        .ontime(ontime_r[gi]),
        .count(ch_count[gi]),
        .on_eff(ch_on[gi]),
        .running(ch_run[gi]),
        .pulse(pwm[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin muxing: select bit set hands the pin to general i/o
  always_comb begin
    if (pin_function_select_r[`AUX_PINSEL_FIRST_BIT]) begin
      pin_first_nxt.out = gpio_out[0];
      pin_first_nxt.oe = gpio_oe[0];
    end else begin
      pin_first_nxt.out = pwm[0];
      pin_first_nxt.oe = 1'b1;
    end
    if (pin_function_select_r[`AUX_PINSEL_SECOND_BIT]) begin
      pin_second_nxt.out = gpio_out[1];
      pin_second_nxt.oe = gpio_oe[1];
    end else begin
      pin_second_nxt.out = pwm[1];
      pin_second_nxt.oe = 1'b1;
    end
  end

  // pin flops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_first_r <= '0;
      pin_second_r <= '0;
    end else begin
      pin_first_r <= pin_first_nxt;
      pin_second_r <= pin_second_nxt;
    end
  end

  assign pulse_out_first = pin_first_r;
  assign pulse_out_second = pin_second_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_values: assert property (@(posedge mclk)
    $past(!nrst) && nrst |-> period_r[0] == 16'hFFFF && period_r[1] == 16'hFFFF && ontime_r[0] == 16'h0000
      && ontime_r[1] == 16'h0000 && !mode_control_reg_r[8])
    else $error("reset values wrong");

  a_tick_every_two: assert property (@(posedge mclk) disable iff (!nrst)
    tick && !clear |=> !tick ##1 (tick || $past(clear)))
    else $error("step not every two clocks");

  a_count_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    tick && !clear && ch_count[0] == period_r[0] |=> ch_count[0] == 16'h0000)
    else $error("first counter did not wrap at period");

  a_clear_counts: assert property (@(posedge mclk) disable iff (!nrst)
    clear |=> ch_count[0] == 16'h0000 && ch_count[1] == 16'h0000 && !tick)
    else $error("period write did not clear counters");

  a_zero_duty: assert property (@(posedge mclk) disable iff (!nrst)
    ch_on[0] == 16'h0000 |-> !pwm[0])
    else $error("zero on-time produced a pulse");

  a_second_zero: assert property (@(posedge mclk) disable iff (!nrst)
    ch_on[1] == 16'h0000 |-> !pwm[1])
    else $error("zero on-time produced a second pulse");

  a_full_duty: assert property (@(posedge mclk) disable iff (!nrst)
    ch_on[0] > period_r[0] && ch_count[0] <= period_r[0] |-> pwm[0])
    else $error("on-time above period not full duty");

  a_high_time: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pwm[0]) && ch_on[0] == 16'h0001 && period_r[0] != 16'h0000 ##1 !clear |-> pwm[0] ##1 !pwm[0])
    else $error("one-step on-time not two clocks high");

  a_rise_at_start: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pwm[0]) |-> ch_count[0] == 16'h0000)
    else $error("first output rose mid-cycle");

  a_ontime_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !clear && !(tick && ch_count[0] == period_r[0]) |=> $stable(ch_on[0]))
    else $error("on-time changed mid-cycle");

  a_offset_lag: assert property (@(posedge mclk) disable iff (!nrst)
    mode == MODE_OFFSET && tick && !clear && ch_count[0] == period_r[1] && period_r[1] < period_r[0]
      |=> ch_count[1] == 16'h0000 && ch_run[1])
    else $error("second output not started at offset point");

  a_indep_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    mode == MODE_INDEPENDENT && $stable(mode) && tick && !clear && ch_run[1] && ch_count[1] == period_r[1]
      |=> ch_count[1] == 16'h0000)
    else $error("second counter ignored own period");

  a_pin_follow: assert property (@(posedge mclk) disable iff (!nrst)
    !pin_function_select_r[8] |=> pulse_out_first.out == $past(pwm[0]) && pulse_out_first.oe)
    else $error("first pin not carrying pulse");

endmodule : dual_aux_pwm_timer

`default_nettype wire

// [aux_pulse_meter.sv]
// load model on one pulse pin: pull-down level plus edge timing
`timescale 1ns/1ns
`default_nettype none

module aux_pulse_meter (
  input wire logic mclk,
  input wire logic nrst,
  input wire aux_pwm_pkg::pin_drive_s pin,
  output logic lvl,
  output logic [31:0] high_len,
  output logic [31:0] period_len,
  output logic [31:0] rise_at,
  output logic [31:0] run
);
  import aux_pwm_pkg::*;
  logic [31:0] cyc; // free cycle count
  logic lvl_nxt; // resolved pin level
  // released pin falls to the pull-down level
  assign lvl_nxt = pin.oe ? pin.out : 1'b0;
  // time rise, fall and level runs in clock cycles
  always @(posedge mclk) begin
    if (!nrst) begin
      cyc <= 0;
      lvl <= 1'b0;
      high_len <= 0;
      period_len <= 0;
      rise_at <= 0;
      run <= 0;
    end else begin
      cyc <= cyc + 1;
      lvl <= lvl_nxt;
      run <= (lvl_nxt != lvl) ? 32'h1 : run + 1;
      if (lvl_nxt && !lvl) begin // rising edge
        period_len <= cyc - rise_at;
        rise_at <= cyc;
      end
      if (!lvl_nxt && lvl) begin // falling edge
        high_len <= cyc - rise_at;
      end
    end
  end
endmodule : aux_pulse_meter

`default_nettype wire

// [dual_aux_pwm_timer_tb.sv]
// self-checking bench for the dual auxiliary pulse timer
`timescale 1ns/1ns
`default_nettype none

module dual_aux_pwm_timer_tb;
  import aux_pwm_pkg::*;
  logic mclk, nrst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, er;
  logic [1:0] gpio_out, gpio_oe;
  pin_drive_s pin0, pin1;
  logic l0, l1;
  logic [31:0] h0, h1, p0, p1, r0, r1, u0, u1;
  int errors, samples_checked, n;

  ////////////////////////////////////////////////////////////////////////////
  // design and pin loads
  dual_aux_pwm_timer dual_aux_pwm_timer_inst (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pulse_out_first(pin0),
    .pulse_out_second(pin1));
  aux_pulse_meter m0_inst (.mclk(mclk), .nrst(nrst), .pin(pin0), .lvl(l0), .high_len(h0),
    .period_len(p0), .rise_at(r0), .run(u0));
  aux_pulse_meter m1_inst (.mclk(mclk), .nrst(nrst), .pin(pin1), .lvl(l1), .high_len(h1),
    .period_len(p1), .rise_at(r1), .run(u1));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // verdict and end of run
  task print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    // values read right at the edge are the ones the edge samples
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge mclk);
    end
    if (k >= 50) errors++;
    // answer taken at the same edge, then the request is released
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // wait for a first-pin level, bounded
  task wait_l0(input logic v);
    n = 0;
    while (l0 !== v && n < 200) begin
      n++;
      @(negedge mclk);
    end
    // a level that never comes counts as a mismatch
    if (n >= 200) errors++;
  endtask : wait_l0

  ////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped place, full period range, gpio pins
  task t_regs;
    chk({30'h0, pin0}, 32'h1);
    chk({30'h0, pin1}, 32'h3);
    xfer(0, 12'h000, 0);
    chk(rd, 32'h0000FFFF);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h0000FFFF);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h0);
    xfer(0, 12'h00C, 0);
    chk(rd, 32'h0);
    xfer(0, 12'h010, 0);
    chk(rd, 32'h0);
    xfer(0, 12'h020, 0);
    chk({31'h0, er}, 32'h1);
    xfer(1, 12'h000, 32'h0);
    xfer(0, 12'h000, 0);
    chk(rd, 32'h0);
  endtask : t_regs

  // independent periods, duty, full duty, restart
  task t_indep;
    xfer(1, 12'h010, 32'h100);
    xfer(1, 12'h014, 32'h0);
    xfer(1, 12'h008, 32'h3);
    xfer(1, 12'h00C, 32'h9);
    xfer(1, 12'h004, 32'h4);
    xfer(1, 12'h000, 32'h7);
    xfer(0, 12'h01C, 0);
    chk(rd, 32'h0);
    repeat (60) @(negedge mclk);
    chk(p0, 32'd16);
    chk(h0, 32'd6);
    chk({31'h0, l1 === 1'b1 && u1 >= 40}, 32'h1);
    // status: second channel running and held high, first bit masked
    xfer(0, 12'h018, 0);
    chk(rd & 32'hFFFF_FFFE, 32'h6);
    chk({31'h0, er}, 32'h0);
  endtask : t_indep

  // on-time written mid-pulse waits for the next cycle, then zero duty
  task t_ontime;
    wait_l0(1'b0);
    wait_l0(1'b1);
    xfer(1, 12'h008, 32'h1);
    wait_l0(1'b0);
    chk(h0, 32'd6);
    repeat (14) @(negedge mclk);
    chk(h0, 32'd2);
    xfer(1, 12'h008, 32'h0);
    repeat (50) @(negedge mclk);
    chk({31'h0, l0 === 1'b0 && u0 >= 30}, 32'h1);
  endtask : t_ontime

  // offset mode: shared period, own on-times, lagged second rise
  task t_offset;
    xfer(1, 12'h010, 32'h0);
    xfer(1, 12'h008, 32'h2);
    xfer(1, 12'h00C, 32'h3);
    xfer(1, 12'h004, 32'h3);
    xfer(1, 12'h000, 32'h9);
    repeat (100) @(negedge mclk);
    chk(p0, 32'd20);
    chk(p1, 32'd20);
    chk(h0, 32'd4);
    chk(h1, 32'd6);
    chk((r1 - r0 + 32'd20) % 32'd20, 32'd8);
    xfer(1, 12'h014, 32'h180);
    repeat (3) @(negedge mclk);
    chk({30'h0, pin1}, 32'h3);
  endtask : t_offset

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    gpio_out = 2'b10;
    gpio_oe = 2'b11;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(negedge mclk);
    t_regs;
    t_indep;
    t_ontime;
    t_offset;
    print_verdict;
  end

  // watchdog against hangs
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule : dual_aux_pwm_timer_tb

`default_nettype wire
